// ### logic/analog_comparator_regs.sv
// Register file, APB slave and digital control around the analog comparator.
`include "analog_comparator_defs.svh"
`default_nettype none
module analog_comparator_regs
   import analog_comparator_pkg::*;
#(
   parameter int SYNC_DEPTH = `SYNC_STAGES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic comp_raw,
   input wire logic sleep_standby,
   input wire logic sleep_power_down,
   input wire logic clock_held,
   output logic core_enable,
   output logic core_low_current,
   output logic [1:0] core_hysteresis,
   output logic [1:0] core_pos_select,
   output logic [1:0] core_neg_select,
   output logic core_neg_reference,
   output logic [7:0] divider_level,
   output logic pin_out,
   output logic pin_oe,
   output logic event_level,
   output logic irq
);
   bus_state_t bus_state_r;
   bus_state_t bus_state_nxt;
   logic [7:0] control_r;
   logic [7:0] input_sel_r;
   logic [7:0] ref_level_r;
   logic [7:0] irq_en_r;
   logic flag_r;
   logic flag_nxt;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic irq_r;
   logic core_enable_r;
   logic pin_oe_r;
   logic pin_oe_nxt;
   logic neg_reference_r;
   logic neg_reference_nxt;
   logic [7:0] control_nxt;
   logic [7:0] input_sel_nxt;
   logic [7:0] ref_level_nxt;
   logic [7:0] irq_en_nxt;
   logic pready_nxt;
   logic pslverr_nxt;
   logic [31:0] prdata_nxt;
   logic irq_nxt;
   logic [7:0] read_byte;
   logic [2:0] reg_index;
   logic addr_bad;
   logic setup_phase;
   logic access_done;
   logic wr_byte;
   logic wr_control;
   logic wr_input_sel;
   logic wr_ref_level;
   logic wr_irq_en;
   logic wr_status;
   logic comp_active;
   logic level_inverted;
   logic edge_hit;
   edge_select_t edge_sel;

   comparator_link_if link ();

   function automatic logic [7:0] merge_byte(input logic [7:0] old_value,
                                             input logic [7:0] new_value,
                                             input logic [7:0] mask);
      merge_byte = (old_value & ~mask) | (new_value & mask);
   endfunction

   // Bus decode; registers sit one per word at four times their index.
   assign reg_index = paddr[4:2];
   assign addr_bad = (paddr[11:5] != 7'h00) || (paddr[1:0] != 2'h0);
   assign setup_phase = psel & ~penable;
   assign access_done = psel & penable & pready_r;
   assign wr_byte = access_done & pwrite & pstrb[0] & ~pslverr_r;
   assign wr_control = wr_byte && (reg_index == `IDX_CONTROL);
   assign wr_input_sel = wr_byte && (reg_index == `IDX_INPUT_SEL);
   assign wr_ref_level = wr_byte && (reg_index == `IDX_REF_LEVEL);
   assign wr_irq_en = wr_byte && (reg_index == `IDX_IRQ_EN);
   assign wr_status = wr_byte && (reg_index == `IDX_STATUS);

   always_comb begin
      bus_state_nxt = bus_state_r;
      unique case (bus_state_r)
         BUS_IDLE: begin
            if (setup_phase) begin
               bus_state_nxt = BUS_ANSWER;
            end
         end
         BUS_ANSWER: begin
            bus_state_nxt = BUS_IDLE;
         end
         default: begin
            bus_state_nxt = BUS_IDLE;
         end
      endcase
   end

   always_comb begin
      read_byte = 8'h00;
      unique case (reg_index)
         `IDX_CONTROL: read_byte = control_r;
         `IDX_INPUT_SEL: read_byte = input_sel_r & `MASK_INPUT_SEL;
         `IDX_REF_LEVEL: read_byte = ref_level_r;
         `IDX_IRQ_EN: read_byte = irq_en_r & `MASK_IRQ_EN;
         `IDX_STATUS: begin
            read_byte[`BIT_STATE] = link.state;
            read_byte[`BIT_FLAG] = flag_r;
         end
         default: read_byte = 8'h00;
      endcase
   end

   // The answer comes one cycle after setup; captured data stands until the next setup.
   assign pready_nxt = (bus_state_nxt == BUS_ANSWER);
   assign pslverr_nxt = setup_phase ? addr_bad : (pslverr_r & ~access_done);
   assign prdata_nxt = setup_phase ? (addr_bad ? 32'h0000_0000 : {24'h00_0000, read_byte})
      : prdata_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_state_r <= BUS_IDLE;
      end else begin
         bus_state_r <= bus_state_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
      end else begin
         pready_r <= pready_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_r <= 1'b0;
      end else begin
         pslverr_r <= pslverr_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else begin
         prdata_r <= prdata_nxt;
      end
   end

   // Configuration registers; unused bits are never stored.
   assign control_nxt = wr_control ? pwdata[7:0] : control_r;
   assign input_sel_nxt = wr_input_sel
      ? merge_byte(input_sel_r, pwdata[7:0], `MASK_INPUT_SEL) : input_sel_r;
   assign ref_level_nxt = wr_ref_level ? pwdata[7:0] : ref_level_r;
   assign irq_en_nxt = wr_irq_en
      ? merge_byte(irq_en_r, pwdata[7:0], `MASK_IRQ_EN) : irq_en_r;
   assign neg_reference_nxt =
      (input_sel_nxt[`NEG_SEL_HI:`NEG_SEL_LO] == `NEG_SEL_REFERENCE);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_r <= `RST_CONTROL;
      end else begin
         control_r <= control_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_sel_r <= `RST_INPUT_SEL;
      end else begin
         input_sel_r <= input_sel_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_level_r <= `RST_REF_LEVEL;
      end else begin
         ref_level_r <= ref_level_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en_r <= `RST_IRQ_EN;
      end else begin
         irq_en_r <= irq_en_nxt;
      end
   end

   // Registered with the select itself, so the pair never disagree for a cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         neg_reference_r <= 1'b0;
      end else begin
         neg_reference_r <= neg_reference_nxt;
      end
   end

   // Standby stops the comparator unless told to keep running; power-down always does.
   assign comp_active = control_r[`BIT_ENABLE] & ~sleep_power_down
      & ~(sleep_standby & ~control_r[`BIT_KEEP_RUNNING]);

   // The core reports one when the positive input is higher; inversion follows it.
   assign level_inverted = comp_raw ^ input_sel_r[`BIT_INVERT];

   assign link.level_in = level_inverted;
   assign link.run = core_enable_r;
   assign link.hold = clock_held;

   output_edge_sync #(
      .STAGES(SYNC_DEPTH)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .link(link)
   );

   assign edge_sel = edge_select_t'(control_r[`EDGE_SEL_HI:`EDGE_SEL_LO]);
   assign edge_hit = ((edge_sel == EDGE_ANY) & (link.rise | link.fall))
      | ((edge_sel == EDGE_FALL) & link.fall)
      | ((edge_sel == EDGE_RISE) & link.rise);

   // A new edge in the clearing cycle wins, so no event slips through.
   assign flag_nxt = (edge_hit & ~clock_held)
      | (flag_r & ~(wr_status & pwdata[`BIT_FLAG]));

   assign irq_nxt = irq_en_r[`BIT_IRQ_ON] & flag_nxt;
   assign pin_oe_nxt = comp_active & control_r[`BIT_PIN_DRIVE];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_r <= 1'b0;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_enable_r <= 1'b0;
      end else begin
         core_enable_r <= comp_active;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_oe_r <= 1'b0;
      end else begin
         pin_oe_r <= pin_oe_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign irq = irq_r;
   assign core_enable = core_enable_r;
   assign pin_oe = pin_oe_r;
   assign core_low_current = control_r[`BIT_LOW_CURRENT];
   assign core_hysteresis = control_r[`HYST_HI:`HYST_LO];
   assign core_pos_select = input_sel_r[`POS_SEL_HI:`POS_SEL_LO];
   assign core_neg_select = input_sel_r[`NEG_SEL_HI:`NEG_SEL_LO];
   assign core_neg_reference = neg_reference_r;
   assign divider_level = ref_level_r;

   // Pin and event follow the core without the clock, since both must work in standby.
   assign pin_out = level_inverted & pin_oe_r;
   assign event_level = level_inverted & core_enable_r;
endmodule
`default_nettype wire

// ### logic/analog_comparator_defs.svh
// Register indices, field positions, reset values and timing counts of the comparator block.
`ifndef ANALOG_COMPARATOR_DEFS_SVH
`define ANALOG_COMPARATOR_DEFS_SVH

`define IDX_CONTROL 3'h0
`define IDX_RESERVED_A 3'h1
`define IDX_INPUT_SEL 3'h2
`define IDX_RESERVED_B 3'h3
`define IDX_REF_LEVEL 3'h4
`define IDX_RESERVED_C 3'h5
`define IDX_IRQ_EN 3'h6
`define IDX_STATUS 3'h7

`define BIT_KEEP_RUNNING 7
`define BIT_PIN_DRIVE 6
`define EDGE_SEL_HI 5
`define EDGE_SEL_LO 4
`define BIT_LOW_CURRENT 3
`define HYST_HI 2
`define HYST_LO 1
`define BIT_ENABLE 0

`define BIT_INVERT 7
`define POS_SEL_HI 4
`define POS_SEL_LO 3
`define NEG_SEL_HI 1
`define NEG_SEL_LO 0
`define NEG_SEL_REFERENCE 2'h3

`define BIT_IRQ_ON 0
`define BIT_STATE 4
`define BIT_FLAG 0

`define RST_CONTROL 8'h00
`define RST_INPUT_SEL 8'h00
`define RST_REF_LEVEL 8'hFF
`define RST_IRQ_EN 8'h00
`define MASK_INPUT_SEL 8'h9B
`define MASK_IRQ_EN 8'h01

`define SYNC_STAGES 3

`endif

// ### logic/analog_comparator_pkg.sv
// Types shared by the comparator control logic.
`default_nettype none
package analog_comparator_pkg;
   typedef enum logic [1:0] {
      EDGE_ANY = 2'h0,
      EDGE_RESERVED = 2'h1,
      EDGE_FALL = 2'h2,
      EDGE_RISE = 2'h3
   } edge_select_t;

   typedef enum logic [1:0] {
      HYST_NONE = 2'h0,
      HYST_SMALL = 2'h1,
      HYST_MEDIUM = 2'h2,
      HYST_LARGE = 2'h3
   } hysteresis_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ANSWER = 2'b10
   } bus_state_t;
endpackage
`default_nettype wire

// ### logic/comparator_link_if.sv
// Signals between the register block and the output synchroniser.
`default_nettype none
interface comparator_link_if;
   logic level_in;
   logic run;
   logic hold;
   logic state;
   logic rise;
   logic fall;
   modport detector(input level_in, input run, input hold, output state, output rise, output fall);
   modport owner(output level_in, output run, output hold, input state, input rise, input fall);
endinterface
`default_nettype wire

// ### logic/output_edge_sync.sv
// Synchroniser and edge detector for the comparator output.
`include "analog_comparator_defs.svh"
`default_nettype none
module output_edge_sync
   import analog_comparator_pkg::*;
#(
   parameter int STAGES = `SYNC_STAGES
) (
   input wire logic pclk,
   input wire logic presetn,
   comparator_link_if.detector link
);
   logic [STAGES-1:0] sync_r;
   logic prev_r;
   logic synced;

   // The first stage feeds only the next stage; everything else looks at the last one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_r <= '0;
         prev_r <= 1'b0;
      end else if (!link.hold) begin
         sync_r <= {sync_r[STAGES-2:0], link.level_in};
         prev_r <= sync_r[STAGES-1];
      end
   end

   assign synced = sync_r[STAGES-1];
   assign link.state = synced;
   // A frozen pair keeps its difference, so an edge caught just before a hold is not lost.
   assign link.rise = link.run & synced & ~prev_r;
   assign link.fall = link.run & ~synced & prev_r;
endmodule
`default_nettype wire

// ### tb/acmp_asserts.sv
// Port-level property checker for the comparator register block.
`default_nettype none
module acmp_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic pslverr,
   input wire logic clock_held,
   input wire logic sleep_power_down,
   input wire logic core_enable,
   input wire logic [1:0] core_neg_select,
   input wire logic core_neg_reference,
   input wire logic pin_out,
   input wire logic pin_oe,
   input wire logic event_level,
   input wire logic irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_PIN_GATE: assert property (!pin_oe |-> !pin_out)
      else $error("pin driven while pad is off");
   AST_OE_CORE: assert property (pin_oe |-> core_enable)
      else $error("pad enabled with core off");
   AST_EVENT_GATE: assert property (!core_enable |-> !event_level)
      else $error("event while core off");
   AST_NEG_REF: assert property (core_neg_reference == (core_neg_select == 2'h3))
      else $error("reference select wrong");
   AST_SAME_LEVEL: assert property (pin_oe && core_enable |-> pin_out == event_level)
      else $error("pin and event disagree");
   // A finished write may move the enable, so only quiet bus cycles are judged.
   AST_IRQ_HOLD: assert property (irq && !psel && !$past(psel) |=> irq)
      else $error("request dropped without clear");
   AST_HELD: assert property (clock_held && !psel && !$past(psel) |=> $stable(irq))
      else $error("request moved while clock held");
   AST_SLVERR: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("misaligned access accepted");
   AST_PWRDN: assert property (sleep_power_down |=> !core_enable)
      else $error("core on in power down");
   COV_IRQ: cover property ($rose(irq));
   COV_PIN: cover property (pin_oe && pin_out);
   COV_ERR: cover property (pslverr);
endmodule
bind analog_comparator_regs acmp_chk i_acmp_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pslverr(pslverr),
   .clock_held(clock_held), .sleep_power_down(sleep_power_down), .core_enable(core_enable),
   .core_neg_select(core_neg_select), .core_neg_reference(core_neg_reference),
   .pin_out(pin_out), .pin_oe(pin_oe), .event_level(event_level), .irq(irq));
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the comparator register block.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'hF;
   logic comp_raw = 1'b0, sleep_standby = 1'b0, sleep_power_down = 1'b0, clock_held = 1'b0;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, core_enable, core_low_current, core_neg_reference;
   wire logic pin_out, pin_oe, event_level, irq;
   wire logic [1:0] core_hysteresis, core_pos_select, core_neg_select;
   wire logic [7:0] divider_level;
   int n_mismatch = 0, n_tests = 0;
   always #4 pclk = ~pclk;
   analog_comparator_regs i_analog_comparator_regs (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .comp_raw(comp_raw),
      .sleep_standby(sleep_standby), .sleep_power_down(sleep_power_down),
      .clock_held(clock_held), .core_enable(core_enable), .core_low_current(core_low_current),
      .core_hysteresis(core_hysteresis), .core_pos_select(core_pos_select),
      .core_neg_select(core_neg_select), .core_neg_reference(core_neg_reference),
      .divider_level(divider_level), .pin_out(pin_out), .pin_oe(pin_oe),
      .event_level(event_level), .irq(irq));
   task automatic conclude;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Outputs are read at the completing edge, before that edge's updates land.
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] x);
      logic [7:0] q;
      logic e;
      apb(1'b0, a, 8'h00, q, e);
      chk(q, x);
   endtask
   task automatic t_regs;
      logic [1:0] v;
      logic [7:0] q;
      logic e;
      rd(12'h000, 8'h00);
      rd(12'h008, 8'h00);
      rd(12'h010, 8'hFF);
      rd(12'h018, 8'h00);
      rd(12'h01C, 8'h00);
      for (int i = 0; i < 4; i++) begin
         v = 2'(i);
         wr(12'h000, {4'h1, v, 1'b0});
         wr(12'h008, {3'h0, v, 1'b0, v});
         repeat (2) @(posedge pclk);
         chk(8'(core_hysteresis), 8'(v));
         chk(8'(core_pos_select), 8'(v));
         chk(8'(core_neg_select), 8'(v));
         chk(8'(core_neg_reference), 8'(v == 2'h3));
         chk(8'(core_low_current), 8'h01);
      end
      wr(12'h008, 8'hFF);
      rd(12'h008, 8'h9B);
      wr(12'h010, 8'h5A);
      rd(12'h010, 8'h5A);
      chk(divider_level, 8'h5A);
      pstrb <= 4'h0;
      wr(12'h010, 8'h11);
      pstrb <= 4'hF;
      rd(12'h010, 8'h5A);
      wr(12'h004, 8'hFF);
      rd(12'h004, 8'h00);
      wr(12'h018, 8'hFE);
      rd(12'h018, 8'h00);
      apb(1'b0, 12'h001, 8'h00, q, e);
      chk(8'(e), 8'h01);
      wr(12'h008, 8'h00);
   endtask
   task automatic t_edges;
      logic [1:0] m;
      wr(12'h018, 8'h01);
      for (int i = 0; i < 4; i++) begin
         m = 2'(i);
         wr(12'h000, {2'h0, m, 4'h1});
         wr(12'h01C, 8'h01);
         comp_raw <= 1'b1;
         repeat (8) @(posedge pclk);
         chk(8'(irq), 8'(m == 2'h0 || m == 2'h3));
         rd(12'h01C, {7'h08, m == 2'h0 || m == 2'h3});
         wr(12'h01C, 8'h01);
         comp_raw <= 1'b0;
         repeat (8) @(posedge pclk);
         rd(12'h01C, {7'h00, m == 2'h0 || m == 2'h2});
      end
      wr(12'h01C, 8'h01);
      comp_raw <= 1'b1;
      repeat (8) @(posedge pclk);
      wr(12'h01C, 8'h00);
      rd(12'h01C, 8'h11);
      wr(12'h018, 8'h00);
      repeat (2) @(posedge pclk);
      chk(8'(irq), 8'h00);
      wr(12'h01C, 8'h01);
      rd(12'h01C, 8'h10);
   endtask
   task automatic t_pin_sleep;
      wr(12'h000, 8'h41);
      repeat (2) @(posedge pclk);
      chk(8'(pin_oe), 8'h01);
      chk(8'(pin_out), 8'h01);
      chk(8'(event_level), 8'h01);
      wr(12'h008, 8'h80);
      repeat (6) @(posedge pclk);
      chk(8'(event_level), 8'h00);
      rd(12'h01C, 8'h01);
      wr(12'h008, 8'h00);
      wr(12'h000, 8'h01);
      sleep_standby <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(8'(pin_oe), 8'h00);
      chk(8'(core_enable), 8'h00);
      wr(12'h000, 8'h81);
      repeat (2) @(posedge pclk);
      chk(8'(core_enable), 8'h01);
      wr(12'h01C, 8'h01);
      clock_held <= 1'b1;
      comp_raw <= 1'b0;
      repeat (8) @(posedge pclk);
      rd(12'h01C, 8'h10);
      clock_held <= 1'b0;
      sleep_standby <= 1'b0;
      repeat (8) @(posedge pclk);
      rd(12'h01C, 8'h01);
      sleep_power_down <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(8'(core_enable), 8'h00);
      sleep_power_down <= 1'b0;
      wr(12'h000, 8'h30);
      wr(12'h01C, 8'h01);
      comp_raw <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(8'(event_level), 8'h00);
      repeat (4) @(posedge pclk);
      rd(12'h01C, 8'h10);
      // The state bit lags by three edges: a read one edge early still sees the old level.
      comp_raw <= 1'b0;
      @(posedge pclk);
      rd(12'h01C, 8'h10);
      comp_raw <= 1'b1;
      repeat (2) @(posedge pclk);
      rd(12'h01C, 8'h10);
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_edges();
      t_pin_sleep();
      conclude();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      conclude();
   end
endmodule
`default_nettype wire
